// ==== hdl/int_gate_pkg.sv ====
// constants and carrier types for the interrupt enable and request block
package int_gate_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [15:0] EDGE_SELECT_ADDR = 16'hfff2;
  localparam logic [15:0] ENABLE_ONE_ADDR = 16'hfff3;
  localparam logic [15:0] ENABLE_TWO_ADDR = 16'hfff4;
  localparam logic [15:0] FLAGS_ONE_ADDR = 16'hfff6;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LINE0_EDGE_POLARITY_BIT = 0;
  localparam int TIMER_A_BIT = 7;
  localparam int WAKEUP_BIT = 5;
  localparam int LINE4_BIT = 4;
  localparam int LINE3_BIT = 3;
  localparam int EVENT_PIN_BIT = 2;
  localparam int LINE1_BIT = 1;
  localparam int LINE0_BIT = 0;
  localparam int DIRECT_TRANSFER_BIT = 7;
  localparam int CONVERTER_BIT = 6;
  localparam int TIMER_G_BIT = 4;
  localparam int TIMER_FH_BIT = 3;
  localparam int TIMER_FL_BIT = 2;
  localparam int TIMER_C_BIT = 1;
  localparam int EVENT_COUNTER_BIT = 0;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0] EDGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] EDGE_SELECT_ONES = 8'he0;
  localparam logic [7:0] EDGE_SELECT_WMASK = 8'h01;
  localparam logic [7:0] ENABLE_ONE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_ONE_WMASK = 8'hbf;
  localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;
  localparam logic [7:0] ENABLE_TWO_WMASK = 8'hdf;
  localparam logic [7:0] FLAGS_ONE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h9f;
  localparam logic [7:0] FLAGS_ONE_ONES = 8'h20;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic direct_transfer;
    logic converter;
    logic timer_g;
    logic timer_fh;
    logic timer_fl;
    logic timer_c;
    logic event_counter;
    logic wakeup;
  } periph_req_type;

  typedef struct packed {
    logic timer_a;
    logic wakeup;
    logic line4;
    logic line3;
    logic event_pin;
    logic line1;
    logic line0;
    logic direct_transfer;
    logic converter;
    logic timer_g;
    logic timer_fh;
    logic timer_fl;
    logic timer_c;
    logic event_counter;
  } core_req_type;

endpackage : int_gate_pkg

// ==== hdl/pin_edge_detect.sv ====
// pin synchroniser with selectable edge detection
`timescale 1ns/10ps
module pin_edge_detect #(
  parameter int STAGES = int_gate_pkg::SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic rise_i,
  input wire logic armed_i,
  output logic edge_o
);

  initial begin
    if (STAGES < 2) begin
      $error("pin_edge_detect needs at least two stages");
    end
  end

  logic [STAGES-1:0] sync_reg;
  logic last_reg;
  logic now;

  assign now = sync_reg[STAGES-1];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_reg <= '1;
      last_reg <= 1'b1;
      edge_o <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], pin_i}; // R24
      last_reg <= now;
      edge_o <= armed_i & (rise_i ? (now & ~last_reg) : (~now & last_reg));
    end
  end

endmodule : pin_edge_detect

// ==== hdl/req_flag_bank.sv ====
// sticky request flags, set by events, cleared by writing zero
`timescale 1ns/10ps
module req_flag_bank #(
  parameter int WIDTH = int_gate_pkg::DATA_W,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] flags_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("req_flag_bank needs a positive width");
    end
  end

  logic [WIDTH-1:0] clear;
  logic [WIDTH-1:0] flags_next;

  always_comb begin
    clear = wr_i ? ~wdata_i : '0; // R18
    flags_next = ((flags_o & ~clear) | set_i) & MASK; // R16 R17
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= flags_next;
    end
  end

endmodule : req_flag_bank

// ==== hdl/int_gate_top.sv ====
// interrupt edge select, enable registers and first request flags
//
// Contract
// (R01) line 0 senses falling edges when its polarity bit is 0, rising if 1
// (R02) enable one bit 7 gates timer A overflow requests, reset 0
// (R03) software writes only 0 to reserved bit 6 of enable one
// (R04) enable one bit 5 gates the combined wake-up request, reset 0
// (R05) enable one bits 4 and 3 gate lines 4 and 3, reset 0
// (R06) enable one bit 2 gates the event-counter pin, reset 0
// (R07) enable one bits 1 and 0 gate lines 1 and 0, reset 0
// (R08) enable two bit 7 gates direct-transfer requests, reset 0
// (R09) enable two bit 6 gates converter requests, reset 0
// (R10) software writes only 0 to reserved bit 5 of enable two
// (R11) enable two bit 4 gates timer G capture and overflow, reset 0
// (R12) enable two bit 3 gates timer FH requests, reset 0
// (R13) enable two bit 2 gates timer FL requests, reset 0
// (R14) enable two bit 1 gates timer C requests, reset 0
// (R15) enable two bit 0 gates event counter requests, reset 0
// (R16) source events set their matching flag in request flags one
// (R17) flags stay set on acceptance; software clears them by writing 0
// (R18) writing 0 clears a flag; writing 1 never sets one
// (R19) flag bit 7 sets on timer A overflow and resets to 0
// (R20) software writes only 0 to reserved bit 6 of request flags one
// (R21) line flags set on the selected edge while the pin is interrupt input
// (R22) event pin flag bit 2 sets on its edge while configured
// (R23) a request reaches the core only while flag and enable are both 1
// (R24) pins are synchronised before edge detection, one set per edge
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module int_gate_top #(
  parameter int SYNC_STAGES = int_gate_pkg::SYNC_STAGES
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic EXT_INT_LINE_0_I,
  input wire logic EXT_INT_LINE_1_I,
  input wire logic EXT_INT_LINE_3_I,
  input wire logic EXT_INT_LINE_4_I,
  input wire logic EVENT_COUNTER_INT_PIN_I,
  input wire logic [4:0] PIN_IS_INT_I,
  input wire logic [4:0] PIN_RISE_SEL_I,
  input wire logic TIMER_A_OVF_I,
  input wire int_gate_pkg::periph_req_type PERIPH_REQ_I,
  output int_gate_pkg::core_req_type CORE_REQ_O,
  output logic LINE0_EDGE_POLARITY_O
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("int_gate_top needs at least two synchroniser stages");
    end
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic hit(
    input logic [15:0] addr,
    input logic [15:0] target
  );
    hit = (addr == target);
  endfunction : hit

  function automatic logic [7:0] masked(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    masked = data & mask;
  endfunction : masked

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] edge_select_reg;
  logic [7:0] enable_one_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] flags_one;
  logic [7:0] flags_one_set;
  logic [7:0] rdata_next;
  logic wr_edge;
  logic wr_en_one;
  logic wr_en_two;
  logic wr_flags_one;
  logic line0_edge;
  logic line1_edge;
  logic line3_edge;
  logic line4_edge;
  logic event_pin_edge;
  logic line0_rise;
  int_gate_pkg::core_req_type core_req_next;

  // ****************************************************************
  // write decode
  // ****************************************************************
  always_comb begin
    wr_edge = 1'b0;
    wr_en_one = 1'b0;
    wr_en_two = 1'b0;
    wr_flags_one = 1'b0;
    if (WR_I && hit(ADDR_I, int_gate_pkg::EDGE_SELECT_ADDR)) begin
      wr_edge = 1'b1;
    end else if (WR_I && hit(ADDR_I, int_gate_pkg::ENABLE_ONE_ADDR)) begin
      wr_en_one = 1'b1;
    end else if (WR_I && hit(ADDR_I, int_gate_pkg::ENABLE_TWO_ADDR)) begin
      wr_en_two = 1'b1;
    end else if (WR_I && hit(ADDR_I, int_gate_pkg::FLAGS_ONE_ADDR)) begin
      wr_flags_one = 1'b1;
    end
  end

  // ****************************************************************
  // edge select register
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      edge_select_reg <= int_gate_pkg::EDGE_SELECT_RESET; // R01
    end else if (wr_edge) begin
      edge_select_reg <= masked(WDATA_I, int_gate_pkg::EDGE_SELECT_WMASK);
    end
  end

  assign line0_rise =
    edge_select_reg[int_gate_pkg::LINE0_EDGE_POLARITY_BIT]; // R01

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      LINE0_EDGE_POLARITY_O <= 1'b0;
    end else begin
      LINE0_EDGE_POLARITY_O <= line0_rise;
    end
  end

  // ****************************************************************
  // enable register one
  // ****************************************************************
  // reserved bit 6 is held at zero whatever software writes
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      enable_one_reg <= int_gate_pkg::ENABLE_ONE_RESET; // R02 R04 R05 R06 R07
    end else if (wr_en_one) begin
      enable_one_reg <= masked(WDATA_I, int_gate_pkg::ENABLE_ONE_WMASK); // R03
    end
  end

  // ****************************************************************
  // enable register two
  // ****************************************************************
  // reserved bit 5 is held at zero whatever software writes
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      enable_two_reg <= int_gate_pkg::ENABLE_TWO_RESET; // R08 R09 R11 R12
    end else if (wr_en_two) begin
      enable_two_reg <= masked(WDATA_I, int_gate_pkg::ENABLE_TWO_WMASK); // R10
    end
  end

  // ****************************************************************
  // pin edge detection
  // ****************************************************************
  pin_edge_detect #(
    .STAGES(SYNC_STAGES)
  ) u_line0 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .pin_i(EXT_INT_LINE_0_I),
    .rise_i(line0_rise),
    .armed_i(PIN_IS_INT_I[int_gate_pkg::LINE0_BIT]),
    .edge_o(line0_edge)
  );

  pin_edge_detect #(
    .STAGES(SYNC_STAGES)
  ) u_line1 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .pin_i(EXT_INT_LINE_1_I),
    .rise_i(PIN_RISE_SEL_I[int_gate_pkg::LINE1_BIT]),
    .armed_i(PIN_IS_INT_I[int_gate_pkg::LINE1_BIT]),
    .edge_o(line1_edge)
  );

  pin_edge_detect #(
    .STAGES(SYNC_STAGES)
  ) u_line3 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .pin_i(EXT_INT_LINE_3_I),
    .rise_i(PIN_RISE_SEL_I[int_gate_pkg::LINE3_BIT]),
    .armed_i(PIN_IS_INT_I[int_gate_pkg::LINE3_BIT]),
    .edge_o(line3_edge)
  );

  pin_edge_detect #(
    .STAGES(SYNC_STAGES)
  ) u_line4 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .pin_i(EXT_INT_LINE_4_I),
    .rise_i(PIN_RISE_SEL_I[int_gate_pkg::LINE4_BIT]),
    .armed_i(PIN_IS_INT_I[int_gate_pkg::LINE4_BIT]),
    .edge_o(line4_edge)
  );

  pin_edge_detect #(
    .STAGES(SYNC_STAGES)
  ) u_event_pin (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .pin_i(EVENT_COUNTER_INT_PIN_I),
    .rise_i(PIN_RISE_SEL_I[int_gate_pkg::EVENT_PIN_BIT]),
    .armed_i(PIN_IS_INT_I[int_gate_pkg::EVENT_PIN_BIT]),
    .edge_o(event_pin_edge)
  );

  // ****************************************************************
  // request flags one
  // ****************************************************************
  always_comb begin
    flags_one_set = '0;
    flags_one_set[int_gate_pkg::TIMER_A_BIT] = TIMER_A_OVF_I; // R19
    flags_one_set[int_gate_pkg::LINE4_BIT] = line4_edge; // R21
    flags_one_set[int_gate_pkg::LINE3_BIT] = line3_edge; // R21
    flags_one_set[int_gate_pkg::EVENT_PIN_BIT] = event_pin_edge; // R22
    flags_one_set[int_gate_pkg::LINE1_BIT] = line1_edge; // R21
    flags_one_set[int_gate_pkg::LINE0_BIT] = line0_edge; // R21
  end

  // reserved bit 6 is never stored, so a stray write cannot matter
  req_flag_bank #(
    .WIDTH(8),
    .MASK(int_gate_pkg::FLAGS_ONE_MASK)
  ) u_flags_one (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .set_i(flags_one_set), // R16
    .wr_i(wr_flags_one), // R18 R20
    .wdata_i(WDATA_I),
    .flags_o(flags_one)
  );

  // ****************************************************************
  // request gating toward the core
  // ****************************************************************
  // flags are left alone here; acceptance does not clear them
  always_comb begin
    core_req_next.timer_a = flags_one[int_gate_pkg::TIMER_A_BIT] &
      enable_one_reg[int_gate_pkg::TIMER_A_BIT]; // R02 R23
    core_req_next.wakeup = PERIPH_REQ_I.wakeup &
      enable_one_reg[int_gate_pkg::WAKEUP_BIT]; // R04
    core_req_next.line4 = flags_one[int_gate_pkg::LINE4_BIT] &
      enable_one_reg[int_gate_pkg::LINE4_BIT]; // R05 R23
    core_req_next.line3 = flags_one[int_gate_pkg::LINE3_BIT] &
      enable_one_reg[int_gate_pkg::LINE3_BIT]; // R05 R23
    core_req_next.event_pin = flags_one[int_gate_pkg::EVENT_PIN_BIT] &
      enable_one_reg[int_gate_pkg::EVENT_PIN_BIT]; // R06 R23
    core_req_next.line1 = flags_one[int_gate_pkg::LINE1_BIT] &
      enable_one_reg[int_gate_pkg::LINE1_BIT]; // R07 R23
    core_req_next.line0 = flags_one[int_gate_pkg::LINE0_BIT] &
      enable_one_reg[int_gate_pkg::LINE0_BIT]; // R07 R23
    core_req_next.direct_transfer = PERIPH_REQ_I.direct_transfer &
      enable_two_reg[int_gate_pkg::DIRECT_TRANSFER_BIT]; // R08
    core_req_next.converter = PERIPH_REQ_I.converter &
      enable_two_reg[int_gate_pkg::CONVERTER_BIT]; // R09
    core_req_next.timer_g = PERIPH_REQ_I.timer_g &
      enable_two_reg[int_gate_pkg::TIMER_G_BIT]; // R11
    core_req_next.timer_fh = PERIPH_REQ_I.timer_fh &
      enable_two_reg[int_gate_pkg::TIMER_FH_BIT]; // R12
    core_req_next.timer_fl = PERIPH_REQ_I.timer_fl &
      enable_two_reg[int_gate_pkg::TIMER_FL_BIT]; // R13
    core_req_next.timer_c = PERIPH_REQ_I.timer_c &
      enable_two_reg[int_gate_pkg::TIMER_C_BIT]; // R14
    core_req_next.event_counter = PERIPH_REQ_I.event_counter &
      enable_two_reg[int_gate_pkg::EVENT_COUNTER_BIT]; // R15
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CORE_REQ_O <= '0;
    end else begin
      CORE_REQ_O <= core_req_next; // R17 R23
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rdata_next = int_gate_pkg::READ_IDLE;
    if (!RD_I) begin
      rdata_next = int_gate_pkg::READ_IDLE;
    end else if (hit(ADDR_I, int_gate_pkg::EDGE_SELECT_ADDR)) begin
      rdata_next = edge_select_reg | int_gate_pkg::EDGE_SELECT_ONES;
    end else if (hit(ADDR_I, int_gate_pkg::ENABLE_ONE_ADDR)) begin
      rdata_next = enable_one_reg;
    end else if (hit(ADDR_I, int_gate_pkg::ENABLE_TWO_ADDR)) begin
      rdata_next = enable_two_reg;
    end else if (hit(ADDR_I, int_gate_pkg::FLAGS_ONE_ADDR)) begin
      rdata_next = flags_one | int_gate_pkg::FLAGS_ONE_ONES;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= int_gate_pkg::READ_IDLE;
    end else begin
      RDATA_O <= rdata_next;
    end
  end

endmodule : int_gate_top

// ==== verification/int_gate_checker_assertions.sv ====
// concurrent checks on the ports of the interrupt enable and request block
`timescale 1ns/10ps
module int_gate_checker (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic TIMER_A_OVF_I,
  input wire int_gate_pkg::periph_req_type PERIPH_REQ_I,
  input wire int_gate_pkg::core_req_type CORE_REQ_O,
  input wire logic LINE0_EDGE_POLARITY_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_pol_write;
    WR_I && ADDR_I == int_gate_pkg::EDGE_SELECT_ADDR;
  endsequence

  sequence s_read(logic [15:0] a);
    RD_I && ADDR_I == a;
  endsequence

  // ****************************************************************
  // properties
  // ****************************************************************
  a_polarity_follows: assert property (
    s_pol_write |-> ##2 LINE0_EDGE_POLARITY_O == $past(WDATA_I[0], 2))
    else $error("line0 polarity does not follow its write");
  a_rsvd_en_one: assert property (
    s_read(int_gate_pkg::ENABLE_ONE_ADDR) |=> !RDATA_O[6])
    else $error("reserved enable one bit reads set");
  a_rsvd_en_two: assert property (
    s_read(int_gate_pkg::ENABLE_TWO_ADDR) |=> !RDATA_O[5])
    else $error("reserved enable two bit reads set");
  a_rsvd_flag_bits: assert property (
    s_read(int_gate_pkg::FLAGS_ONE_ADDR) |=> RDATA_O[6:5] == 2'b01)
    else $error("reserved flag bits read wrong");
  a_periph_gated: assert property (
    1'b1 |=> (CORE_REQ_O[6:0] & ~$past(PERIPH_REQ_I[7:1])) == 7'h00)
    else $error("peripheral request passed without its source");
  a_wakeup_gated: assert property (
    !PERIPH_REQ_I.wakeup |=> !CORE_REQ_O.wakeup)
    else $error("wake-up request passed without its source");
  a_timer_a_kept: assert property (
    CORE_REQ_O.timer_a && !$past(WR_I) |=> CORE_REQ_O.timer_a)
    else $error("timer a request dropped without a write");
  a_timer_a_cause: assert property (
    $rose(CORE_REQ_O.timer_a) |-> $past(TIMER_A_OVF_I, 2) || $past(WR_I, 2))
    else $error("timer a request rose without overflow or write");
endmodule : int_gate_checker

bind int_gate_top int_gate_checker int_gate_checker_i (
  .CORE_CLK_I(CORE_CLK_I),
  .RSTN_I(RSTN_I),
  .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I),
  .WR_I(WR_I),
  .RD_I(RD_I),
  .RDATA_O(RDATA_O),
  .TIMER_A_OVF_I(TIMER_A_OVF_I),
  .PERIPH_REQ_I(PERIPH_REQ_I),
  .CORE_REQ_O(CORE_REQ_O),
  .LINE0_EDGE_POLARITY_O(LINE0_EDGE_POLARITY_O)
);

// ==== verification/core_accept_model.sv ====
// processor core model that accepts pending interrupt requests
`timescale 1ns/10ps
module core_accept_model #(
  parameter int DELAY = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire int_gate_pkg::core_req_type req_i,
  output logic taken_o
);
  int wait_cnt;

  // acceptance never touches the flags; software has to clear them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 0;
      taken_o <= 1'b0;
    end else if (req_i == '0) begin
      wait_cnt <= 0;
      taken_o <= 1'b0;
    end else if (wait_cnt == DELAY) begin
      taken_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : core_accept_model

// ==== verification/int_gate_top_tb_top.sv ====
// self-checking testbench for the interrupt enable and request block
`timescale 1ns/10ps
module int_gate_top_tb_top;
  logic clk, rst_n, wr, rd, tmr, pol, taken;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, en1, en2, per;
  logic [4:0] pins, pin_int, rise;
  int_gate_pkg::core_req_type core;
  int failures, cmp_count;

  int_gate_top int_gate_top_i (
    .CORE_CLK_I(clk),
    .RSTN_I(rst_n),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .EXT_INT_LINE_0_I(pins[0]),
    .EXT_INT_LINE_1_I(pins[1]),
    .EXT_INT_LINE_3_I(pins[3]),
    .EXT_INT_LINE_4_I(pins[4]),
    .EVENT_COUNTER_INT_PIN_I(pins[2]),
    .PIN_IS_INT_I(pin_int),
    .PIN_RISE_SEL_I(rise),
    .TIMER_A_OVF_I(tmr),
    .PERIPH_REQ_I(per),
    .CORE_REQ_O(core),
    .LINE0_EDGE_POLARITY_O(pol)
  );

  core_accept_model core_accept_model_i (
    .clk_i(clk),
    .rst_n_i(rst_n),
    .req_i(core),
    .taken_o(taken)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [13:0] exp_core(input logic [7:0] p, e1, e2, f);
    return {f[7] & e1[7], p[0] & e1[5], f[4:0] & e1[4:0],
      p[7:6] & e2[7:6], p[5:1] & e2[4:0]};
  endfunction : exp_core

  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [13:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("read %h", a), {6'h0, e}, {6'h0, rdata});
  endtask : rd_reg

  task automatic pin_step(input int b, input logic lvl, input logic [7:0] f);
    @(posedge clk);
    pins[b] <= lvl;
    repeat (6) @(posedge clk);
    #1 chk("core pin", exp_core(per, en1, en2, f), core);
    rd_reg(16'hfff6, f | 8'h20);
    wr_reg(16'hfff6, 8'h00);
  endtask : pin_step

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    {wr, rd, tmr, addr, wdata, per, en1, en2, rise} = '0;
    pins = 5'h1f;
    pin_int = 5'h1f;
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(16'hfff2, 8'he0);
    rd_reg(16'hfff3, 8'h00);
    rd_reg(16'hfff4, 8'h00);
    rd_reg(16'hfff6, 8'h20);
    rd_reg(16'h0000, 8'h00);
    chk("polarity", 14'h0, {13'h0, pol});
    wr_reg(16'hfff3, 8'hbf);
    en1 = 8'hbf;
    wr_reg(16'hfff4, 8'hdf);
    en2 = 8'hdf;
    rd_reg(16'hfff3, 8'hbf);
    rd_reg(16'hfff4, 8'hdf);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 9; k++) begin
        @(posedge clk);
        per <= (k == 8) ? 8'hff : 8'h01 << k;
        repeat (2) @(posedge clk);
        #1 chk("gated", exp_core(per, en1, en2, 8'h00), core);
      end
      wr_reg(16'hfff4, 8'h00);
      en2 = 8'h00;
      wr_reg(16'hfff3, 8'h1f);
      en1 = 8'h1f;
    end
    wr_reg(16'hfff3, 8'h80);
    en1 = 8'h80;
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    rd_reg(16'hfff6, 8'ha0);
    wr_reg(16'hfff6, 8'hbf);
    rd_reg(16'hfff6, 8'ha0);
    for (int n = 0; n < 20 && taken !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("accept", 14'h1, {13'h0, taken});
    chk("core kept", exp_core(per, en1, en2, 8'h80), core);
    wr_reg(16'hfff6, 8'h3f);
    rd_reg(16'hfff6, 8'h20);
    chk("core clear", exp_core(per, en1, en2, 8'h00), core);
    wr_reg(16'hfff3, 8'h00);
    en1 = 8'h00;
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    rd_reg(16'hfff6, 8'ha0);
    chk("core off", exp_core(per, en1, en2, 8'h80), core);
    wr_reg(16'hfff6, 8'h00);
    wr_reg(16'hfff3, 8'h1f);
    en1 = 8'h1f;
    for (int m = 0; m < 2; m++) begin
      for (int b = 0; b < 5; b++) begin
        rise <= {{4{m[0]}}, ~m[0]};
        wr_reg(16'hfff2, {7'h0, m[0]});
        pin_step(b, 1'b0, m[0] ? 8'h00 : 8'h01 << b);
        pin_step(b, 1'b1, m[0] ? 8'h01 << b : 8'h00);
      end
    end
    rd_reg(16'hfff2, 8'he1);
    chk("polarity", 14'h1, {13'h0, pol});
    @(posedge clk);
    pin_int <= 5'h1d;
    pin_step(1, 1'b0, 8'h00);
    pin_step(1, 1'b1, 8'h00);
    report_and_stop();
  end
endmodule : int_gate_top_tb_top
